/* File: design/mft_route.sv */
// multifunction terminal routing, speaker xor, ring/pme, eeprom load
`timescale 1ns/1ps

// Functional notes
// - terminal zero: inta, gpio0, led, zv, pwm, gpe, irq
// - terminal one: gpio1, led, zv, pwm, gpe, irq
// - terminal two: dma request, gpio2, ring, others
// - terminal three: parallel irq or serialized interrupt
// - terminal four: lock, gpio3, ring, others
// - terminal five: dma grant, gpio4, others
// - terminal six: clkrun or parallel irq
// - both supply controls high: terminal one is data
// - both supply controls high: terminal four is clock
// - after pci reset with both supply controls high, load defaults from eeprom
// - speaker output is xor of card audio
// - dedicated output carries ring or pme
// - suspend keeps general inputs and load data through pci and global resets
module mft_route
  import mft_pkg::*;
#(
  parameter int NUM_SOCK = 2
) (
  // clock and resets
  input  wire logic                 SYS_CLK,
  input  wire logic                 RESET,
  input  wire logic                 PCI_RESET_IN,
  input  wire logic                 GLOBAL_RESET_IN,
  input  wire logic                 SUSPEND,
  // configuration
  input  wire logic [7*SEL_W-1:0]   FUNC_SEL,
  input  wire logic                 RING_SEL_PME,
  input  wire logic                 SOCKET_SUPPLY_CTL_ZERO,
  input  wire logic                 SOCKET_SUPPLY_CTL_ONE,
  // internal sources
  input  mft_src_s                  SRC,
  input  wire logic                 PME,
  input  wire logic [NUM_SOCK-1:0]  CARD_AUDIO,
  // sampled inputs
  output logic [4:0]                GENERAL_INPUT,
  output logic                      DMA_GRANT,
  output logic                      LOCK_IN,
  output logic                      SERIRQ_IN,
  output logic                      CLKRUN_IN,
  // eeprom results
  output logic [LOAD_BITS-1:0]      LOAD_DATA,
  output logic                      LOAD_BUSY,
  // terminals
  input  wire logic [6:0]           MULTI_PIN_IN,
  output logic [6:0]                MULTI_PIN_OUT,
  output logic [6:0]                MULTI_PIN_OE,
  output logic                      RING_INDICATE_OUTPUT,
  output logic                      SPEAKER_OUTPUT
);

  logic [SEL_W-1:0]     sel [7];
  logic [6:0]           pin_out;
  logic [6:0]           pin_oe;
  logic                 eeprom_mode;
  logic                 next_eeprom_mode;
  mft_ld_e              ld_state;
  mft_ld_e              next_ld_state;
  logic [7:0]           ld_cnt;
  logic [7:0]           next_ld_cnt;
  logic [4:0]           ld_bit;
  logic [4:0]           next_ld_bit;
  logic [LOAD_BITS-1:0] next_load_data;
  logic [4:0]           next_gpi;
  logic                 next_spk;
  logic                 next_ring;
  logic                 soft_rst;

  // suspend shields state from both device resets
  assign soft_rst = (PCI_RESET_IN | GLOBAL_RESET_IN) & ~SUSPEND;

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      sel[i] = FUNC_SEL[i*SEL_W +: SEL_W];
    end
  end

  // shared mux of the common functions for one terminal
  function automatic logic [1:0] common_fn(input logic [3:0] s,
                                           input logic       gpo,
                                           input logic       irq);
    case (s)
      FN_IRQ:  common_fn = {irq, 1'b1};
      FN_GPI:  common_fn = 2'b00;
      FN_GPO:  common_fn = {gpo, 1'b1};
      FN_LED:  common_fn = {SRC.led, 1'b1};
      FN_ZV:   common_fn = {SRC.zv, 1'b1};
      FN_PWM:  common_fn = {SRC.pwm, 1'b1};
      FN_GPE:  common_fn = {SRC.general_purpose_event, 1'b1};
      default: common_fn = 2'b00;
    endcase
  endfunction

  always_comb begin
    {pin_out[0], pin_oe[0]} = common_fn(sel[0], SRC.gpo[0], SRC.irq[0]);
    if (sel[0] == FN_SPECIAL) begin
      {pin_out[0], pin_oe[0]} = {SRC.inta, 1'b1};
    end
    {pin_out[1], pin_oe[1]} = common_fn(sel[1], SRC.gpo[1],
                                        SRC.irq[1]);
    {pin_out[2], pin_oe[2]} = common_fn(sel[2], SRC.gpo[2], SRC.irq[2]);
    if (sel[2] == FN_SPECIAL) begin
      {pin_out[2], pin_oe[2]} = {SRC.dma_req, 1'b1};
    end else if (sel[2] == FN_RING) begin
      {pin_out[2], pin_oe[2]} = {SRC.ring, 1'b1};
    end
    // terminal three: irq or serialized interrupt only
    if (sel[3] == FN_SPECIAL) begin
      {pin_out[3], pin_oe[3]} = {SRC.serirq_out, SRC.serirq_oe};
    end else begin
      {pin_out[3], pin_oe[3]} = {SRC.irq[3], 1'b1};
    end
    {pin_out[4], pin_oe[4]} = common_fn(sel[4], SRC.gpo[3], SRC.irq[4]);
    if (sel[4] == FN_SPECIAL) begin
      {pin_out[4], pin_oe[4]} = {SRC.lock_out, SRC.lock_oe};
    end else if (sel[4] == FN_RING) begin
      {pin_out[4], pin_oe[4]} = {SRC.ring, 1'b1};
    end
    {pin_out[5], pin_oe[5]} = common_fn(sel[5], SRC.gpo[4], SRC.irq[5]);
    if (sel[5] == FN_SPECIAL) begin
      pin_oe[5] = 1'b0;
    end
    if (sel[6] == FN_SPECIAL) begin
      {pin_out[6], pin_oe[6]} = {SRC.clkrun_out, SRC.clkrun_oe};
    end else begin
      {pin_out[6], pin_oe[6]} = {SRC.irq[6], 1'b1};
    end
    // eeprom load owns terminals one and four
    if (eeprom_mode) begin
      pin_out[1] = 1'b0;
      pin_oe[1]  = 1'b0;
      pin_out[4] = 1'b0;
      pin_oe[4]  = (ld_state == LD_LOW);
    end
  end

  // open-drain clock: driven low in low phase, released otherwise
  assign MULTI_PIN_OUT = pin_out;
  assign MULTI_PIN_OE  = pin_oe;

  // decode inputs only when that function is selected
  always_comb begin
    next_gpi    = GENERAL_INPUT;
    next_gpi[0] = (sel[0] == FN_GPI) ? MULTI_PIN_IN[0] : 1'b0;
    next_gpi[1] = (sel[1] == FN_GPI && !eeprom_mode) ? MULTI_PIN_IN[1] : 1'b0;
    next_gpi[2] = (sel[2] == FN_GPI) ? MULTI_PIN_IN[2] : 1'b0;
    next_gpi[3] = (sel[4] == FN_GPI && !eeprom_mode) ? MULTI_PIN_IN[4] : 1'b0;
    next_gpi[4] = (sel[5] == FN_GPI) ? MULTI_PIN_IN[5] : 1'b0;
    next_spk    = ^CARD_AUDIO;
    next_ring   = RING_SEL_PME ? PME : SRC.ring;
  end

  assign DMA_GRANT = (sel[5] == FN_SPECIAL) & MULTI_PIN_IN[5];
  assign LOCK_IN   = (sel[4] == FN_SPECIAL) & MULTI_PIN_IN[4];
  assign SERIRQ_IN = (sel[3] == FN_SPECIAL) & MULTI_PIN_IN[3];
  assign CLKRUN_IN = (sel[6] == FN_SPECIAL) & MULTI_PIN_IN[6];
  assign LOAD_BUSY = eeprom_mode;

  // serial loader: clocks LOAD_BITS data bits in after pci reset
  always_comb begin
    next_ld_state    = ld_state;
    next_ld_cnt      = ld_cnt;
    next_ld_bit      = ld_bit;
    next_load_data   = LOAD_DATA;
    next_eeprom_mode = eeprom_mode;
    case (ld_state)
      LD_IDLE: begin
        if (eeprom_mode) begin
          next_ld_state = LD_LOW;
          next_ld_cnt   = 8'h00;
          next_ld_bit   = 5'h00;
        end
      end
      LD_LOW: begin
        if (ld_cnt == 8'(SCL_HALF_CY - 1)) begin
          next_ld_state = LD_HIGH;
          next_ld_cnt   = 8'h00;
        end else begin
          next_ld_cnt = ld_cnt + 8'h01;
        end
      end
      LD_HIGH: begin
        if (ld_cnt == 8'(SCL_HALF_CY - 1)) begin
          next_load_data = {LOAD_DATA[LOAD_BITS-2:0],
                            MULTI_PIN_IN[1]};
          next_ld_cnt    = 8'h00;
          next_ld_bit    = ld_bit + 5'h01;
          next_ld_state  = (ld_bit == 5'(LOAD_BITS - 1)) ? LD_DONE : LD_LOW;
        end else begin
          next_ld_cnt = ld_cnt + 8'h01;
        end
      end
      LD_DONE: begin
        next_eeprom_mode = 1'b0;
        next_ld_state    = LD_IDLE;
      end
      default: next_ld_state = LD_IDLE;
    endcase
    // strap sampled as pci reset is released
    if (PCI_RESET_IN) begin
      next_eeprom_mode = SOCKET_SUPPLY_CTL_ZERO
                       & SOCKET_SUPPLY_CTL_ONE;
      next_ld_state    = LD_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ld_state             <= LD_IDLE;
      ld_cnt               <= 8'h00;
      ld_bit               <= 5'h00;
      eeprom_mode          <= 1'b0;
      LOAD_DATA            <= '0;
      GENERAL_INPUT        <= 5'h00;
      SPEAKER_OUTPUT       <= 1'b0;
      RING_INDICATE_OUTPUT <= 1'b0;
    end else begin
      ld_state             <= next_ld_state;
      ld_cnt               <= next_ld_cnt;
      ld_bit               <= next_ld_bit;
      eeprom_mode          <= next_eeprom_mode;
      LOAD_DATA            <= (soft_rst && !PCI_RESET_IN)
                              ? '0 : next_load_data;
      GENERAL_INPUT        <= soft_rst ? 5'h00 : next_gpi;
      SPEAKER_OUTPUT       <= next_spk;
      RING_INDICATE_OUTPUT <= next_ring;
    end
  end

  spk_xor_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) 1'b1
    |=> SPEAKER_OUTPUT == ^$past(CARD_AUDIO))
    else $error("speaker not xor of audio");
  ring_pme_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) RING_SEL_PME
    |=> RING_INDICATE_OUTPUT == $past(PME))
    else $error("ring output not pme");
  t3_irq_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[3] != FN_SPECIAL
    |-> MULTI_PIN_OE[3] && MULTI_PIN_OUT[3] == SRC.irq[3])
    else $error("terminal three irq wrong");
  t6_clk_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[6] == FN_SPECIAL
    |-> MULTI_PIN_OE[6] == SRC.clkrun_oe && CLKRUN_IN == MULTI_PIN_IN[6])
    else $error("terminal six clkrun wrong");
  gpi_off_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[0] == FN_GPI
    |-> !MULTI_PIN_OE[0])
    else $error("input terminal driven");
  t0_inta_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[0] == FN_SPECIAL
    |-> MULTI_PIN_OE[0] && MULTI_PIN_OUT[0] == SRC.inta)
    else $error("terminal zero inta wrong");
  sda_rel_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) eeprom_mode
    |-> !MULTI_PIN_OE[1])
    else $error("data line driven in load");
  ld_start_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) $fell(PCI_RESET_IN) && eeprom_mode
    |-> ##1 ld_state == LD_LOW)
    else $error("load did not start");
  scl_low_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) eeprom_mode && ld_state == LD_LOW
    |-> MULTI_PIN_OE[4] && !MULTI_PIN_OUT[4])
    else $error("clock not pulled low");
  susp_hold_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) SUSPEND && GLOBAL_RESET_IN && !PCI_RESET_IN
    && ld_state == LD_IDLE |=> LOAD_DATA == $past(LOAD_DATA))
    else $error("suspend lost state");
  t2_ring_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[2] == FN_RING
    |-> MULTI_PIN_OE[2] && MULTI_PIN_OUT[2] == SRC.ring)
    else $error("terminal two ring wrong");
  t1_gpo_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[1] == FN_GPO && !eeprom_mode
    |-> MULTI_PIN_OE[1] && MULTI_PIN_OUT[1] == SRC.gpo[1])
    else $error("terminal one gpo wrong");
  t2_dma_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[2] == FN_SPECIAL
    |-> MULTI_PIN_OE[2] && MULTI_PIN_OUT[2] == SRC.dma_req)
    else $error("terminal two dma request wrong");
  t4_lock_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[4] == FN_SPECIAL && !eeprom_mode
    |-> MULTI_PIN_OE[4] == SRC.lock_oe && LOCK_IN == MULTI_PIN_IN[4])
    else $error("terminal four lock wrong");
  t5_grant_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[5] == FN_SPECIAL
    |-> !MULTI_PIN_OE[5] && DMA_GRANT == MULTI_PIN_IN[5])
    else $error("terminal five grant wrong");
  t3_ser_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) sel[3] == FN_SPECIAL
    |-> MULTI_PIN_OE[3] == SRC.serirq_oe && SERIRQ_IN == MULTI_PIN_IN[3])
    else $error("terminal three serirq wrong");
  scl_rel_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) eeprom_mode && ld_state == LD_HIGH
    |-> !MULTI_PIN_OE[4])
    else $error("clock held low in high phase");
  gpi_mask_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) eeprom_mode
    |=> !GENERAL_INPUT[1] && !GENERAL_INPUT[3])
    else $error("serial bus seen as input");
  global_reset_in_clr_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) GLOBAL_RESET_IN && !SUSPEND && !PCI_RESET_IN
    |=> GENERAL_INPUT == 5'h00 && LOAD_DATA == '0)
    else $error("global reset did not clear");
  load_end_a: assert property (@(posedge SYS_CLK)
    disable iff (RESET) ld_state == LD_DONE && !PCI_RESET_IN
    |=> !LOAD_BUSY)
    else $error("load busy after done");

  load_c: cover property (@(posedge SYS_CLK) ld_state == LD_DONE);
  serirq_c: cover property (@(posedge SYS_CLK) sel[3] == FN_SPECIAL);
  susp_c: cover property (@(posedge SYS_CLK) SUSPEND && GLOBAL_RESET_IN);
  ring_c: cover property (@(posedge SYS_CLK) sel[2] == FN_RING && SRC.ring);
  grant_c: cover property (@(posedge SYS_CLK) DMA_GRANT);

endmodule // mft_route

/* File: design/mft_pkg.sv */
// package for the multifunction terminal routing block
package mft_pkg;

  // per-terminal function selector width
  localparam int SEL_W = 4;

  // function codes for the selector of each terminal
  localparam logic [3:0] FN_IRQ     = 4'h0;
  localparam logic [3:0] FN_GPI     = 4'h1;
  localparam logic [3:0] FN_GPO     = 4'h2;
  localparam logic [3:0] FN_LED     = 4'h3;
  localparam logic [3:0] FN_ZV      = 4'h4;
  localparam logic [3:0] FN_PWM     = 4'h5;
  localparam logic [3:0] FN_GPE     = 4'h6;
  localparam logic [3:0] FN_SPECIAL = 4'h7;
  localparam logic [3:0] FN_RING    = 4'h8;

  // reset value of every selector: parallel irq
  localparam logic [3:0] SEL_RESET = 4'h0;

  // eeprom loader timing
  localparam int SCL_HALF_NS = 5000;
  localparam int CLK_NS      = 50;
  localparam int SCL_HALF_CY = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_BITS   = 16;

  // internal sources that may reach a terminal
  typedef struct packed {
    logic       inta;
    logic [4:0] gpo;
    logic       led;
    logic       zv;
    logic       pwm;
    logic       general_purpose_event;
    logic [6:0] irq;
    logic       dma_req;
    logic       lock_out;
    logic       lock_oe;
    logic       serirq_out;
    logic       serirq_oe;
    logic       clkrun_out;
    logic       clkrun_oe;
    logic       ring;
  } mft_src_s;

  // one-hot state machine for the eeprom load after pci reset
  typedef enum logic [3:0] {
    LD_IDLE = 4'h1,
    LD_LOW  = 4'h2,
    LD_HIGH = 4'h4,
    LD_DONE = 4'h8
  } mft_ld_e;

endpackage

/* File: verif/mft_eeprom_model.sv */
// serial eeprom partner that answers the default load
`timescale 1ns/1ps
module mft_eeprom_model #(
  parameter logic [15:0] WORD = 16'hA5C3
) (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic busy,
  output logic      sda,
  output logic      sda_oe
);
  logic       scl_q;
  logic [4:0] idx;
  // data changes only while the clock line is low
  always_ff @(posedge clk) begin
    scl_q <= scl;
    if (!busy) begin
      idx    <= 5'h10;
      sda    <= 1'b1;
      sda_oe <= 1'b0;
    end else if (scl_q && !scl) begin
      idx    <= idx - 5'h01;
      sda    <= WORD[idx[3:0] - 4'h1];
      sda_oe <= 1'b1;
    end
  end
endmodule // mft_eeprom_model

/* File: verif/multifunction_terminal_routing_test.sv */
// self-checking bench for the multifunction terminal routing
`timescale 1ns/1ps
module multifunction_terminal_routing_test;
  import mft_pkg::*;
  logic        clk, rst, pci_reset_in, global_reset_in, susp, rsel, vz, vo, pme;
  logic        busy, dg, lk, sq, ck, ring, spk, sda, sda_oe;
  logic [27:0] sel;
  logic [1:0]  aud;
  logic [6:0]  ext, p_out, p_oe, p_in;
  logic [4:0]  gin;
  logic [15:0] ld;
  logic [5:0]  rows [7];
  mft_src_s    src;
  int          fail_count, n_compared, n;

  // undriven pins read the external level, pin one the eeprom
  assign p_in = (p_oe & p_out) |
                (~p_oe & {ext[6:2], sda_oe ? sda : ext[1], ext[0]});

  mft_route dut (.SYS_CLK(clk), .RESET(rst), .PCI_RESET_IN(pci_reset_in),
    .GLOBAL_RESET_IN(global_reset_in), .SUSPEND(susp), .FUNC_SEL(sel),
    .RING_SEL_PME(rsel), .SOCKET_SUPPLY_CTL_ZERO(vz),
    .SOCKET_SUPPLY_CTL_ONE(vo), .SRC(src), .PME(pme),
    .CARD_AUDIO(aud), .GENERAL_INPUT(gin), .DMA_GRANT(dg),
    .LOCK_IN(lk), .SERIRQ_IN(sq), .CLKRUN_IN(ck), .LOAD_DATA(ld),
    .LOAD_BUSY(busy), .MULTI_PIN_IN(p_in), .MULTI_PIN_OUT(p_out),
    .MULTI_PIN_OE(p_oe), .RING_INDICATE_OUTPUT(ring),
    .SPEAKER_OUTPUT(spk));

  mft_eeprom_model eep (.clk(clk), .scl(p_in[4]), .busy(busy),
    .sda(sda), .sda_oe(sda_oe));

  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_vec(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic close_out;
    $display("compares=%0d errors=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {rst, pci_reset_in, global_reset_in, susp, rsel, vz, vo, pme} = 8'h80;
    sel = '0;
    aud = '0;
    ext = 7'h7F;
    src = '0;
    src.gpo = 5'h1F;
    src.zv = 1'b1;
    src.general_purpose_event = 1'b1;
    src.ring = 1'b1;
    fail_count = 0;
    n_compared = 0;
    // {code, out, oe} for the plain driven and sampled functions
    rows = '{{FN_IRQ, 2'b01}, {FN_GPI, 2'b00}, {FN_GPO, 2'b11},
             {FN_LED, 2'b01}, {FN_ZV, 2'b11}, {FN_PWM, 2'b01},
             {FN_GPE, 2'b11}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      sel <= {7{rows[i][5:2]}};
      step(1);
      chk_vec(p_oe & 7'h37, rows[i][0] ? 7'h37 : 7'h00);
      if (rows[i][0])
        chk_vec(p_out & 7'h37, rows[i][1] ? 7'h37 : 7'h00);
    end
    @(posedge clk);
    ext <= 7'h35;
    sel <= {7{FN_GPI}};
    step(2);
    chk_vec(gin, 5'h1D);
    @(posedge clk);
    {susp, global_reset_in} <= 2'b11;
    step(2);
    chk_vec(gin, 5'h1D);
    @(posedge clk);
    susp <= 1'b0;
    step(2);
    chk_vec(gin, 5'h00);
    @(posedge clk);
    global_reset_in <= 1'b0;
    sel <= {7{FN_RING}};
    step(1);
    chk_vec(p_out & p_oe & 7'h14, 7'h14);
    @(posedge clk);
    sel <= {7{FN_SPECIAL}};
    step(1);
    chk_vec(p_oe & 7'h78, 7'h00);
    chk_vec({dg, lk, sq, ck}, 4'hC);
    @(posedge clk);
    ext <= 7'h4A;
    step(1);
    chk_vec({dg, lk, sq, ck}, 4'h3);
    @(posedge clk);
    {aud, pme, rsel} <= 4'h7;
    step(2);
    chk_bit(spk, 1'b1);
    chk_bit(ring, 1'b1);
    @(posedge clk);
    {aud, rsel} <= 3'h6;
    src.ring <= 1'b0;
    step(2);
    chk_bit(spk, 1'b0);
    chk_bit(ring, 1'b0);
    @(posedge clk);
    {vz, vo, pci_reset_in} <= 3'h7;
    ext <= 7'h7F;
    step(2);
    @(posedge clk);
    pci_reset_in <= 1'b0;
    step(3);
    chk_bit(busy, 1'b1);
    step(50);
    chk_bit(p_oe[1], 1'b0);
    chk_bit(p_in[4], 1'b0);
    step(100);
    chk_bit(p_in[4], 1'b1);
    n = 0;
    while (busy && n < 4000) begin
      step(1);
      n++;
    end
    if (busy)
      fail_count++;
    else
      chk_vec(ld, 16'hA5C3);
    // one strap low: pci reset must not start a load nor lose data
    @(posedge clk);
    {vz, pci_reset_in} <= 2'b01;
    step(3);
    chk_bit(busy, 1'b0);
    chk_vec(ld, 16'hA5C3);
    close_out();
  end
endmodule // multifunction_terminal_routing_test
